// ### hdl/dpr_pkg.sv
package dpr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_RATE_STEP_LOW = 16'hC013;
  localparam logic [15:0] IDX_RATE_STEP_HIGH_DOUBLER = 16'hC014;
  localparam logic [15:0] IDX_LEFT_SAMPLE_VALUE = 16'hC015;
  localparam logic [15:0] IDX_RIGHT_SAMPLE_VALUE = 16'hC016;
  localparam logic [15:0] IDX_PIN_DIRECTION = 16'hC017;
  localparam logic [15:0] IDX_PIN_INPUT_LEVELS = 16'hC018;
  localparam logic [15:0] IDX_PIN_OUTPUT_LEVELS = 16'hC019;
  localparam logic [15:0] IDX_IRQ_SOURCE_ENABLE = 16'hC01A;
  localparam logic [15:0] IDX_IRQ_HOLD_INCREMENT = 16'hC01B;
  localparam logic [15:0] IDX_IRQ_HOLD_DECREMENT = 16'hC01C;
  localparam logic [15:0] IDX_IRQ_HOLD_COUNT = 16'hC01D;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hC01E;

  localparam int ADDR_W = 18;
  localparam int ACC_W = 26;
  localparam int STEP_HIGH_W = 4;
  localparam int STEP_SHIFT = 16;
  localparam int CNT_W = 5;
  localparam int GPIO_W = 4;
  localparam int SRC_W = 3;

  // Field positions
  localparam int DOUBLER_BIT = 4;
  localparam int SRC_AUDIO = 0;
  localparam int SRC_CTRL = 1;
  localparam int SRC_DATA = 2;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [4:0] RST_HIGH = 5'h00;
  localparam logic [3:0] RST_GPIO = 4'h0;
  localparam logic [2:0] RST_SRC = 3'h0;
  localparam logic [4:0] RST_CNT = 5'h00;

  // Timing
  localparam logic [1:0] STEP_PERIOD_M1 = 2'h3;

  // Vector words
  localparam logic [7:0] VEC_AUDIO = 8'h20;
  localparam logic [7:0] VEC_CTRL = 8'h21;
  localparam logic [7:0] VEC_DATA = 8'h22;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } dpr_sample_s;

  typedef enum logic {PH_WAIT, PH_DONE} dpr_phase_e;

endpackage : dpr_pkg

// ### hdl/dpr_peripheral.sv
`timescale 1ns/1ps
// Functional notes
// - Every fourth cycle add step to 26-bit accumulator
// - Overflow latches both samples, raises audio request
// - Step high bit four switches doubler on
// - Direction bit one drives pin
// - Input register returns sampled pin levels
// - Output values kept while pins are inputs
// - Port never raises an interrupt
// - Enable bits gate data, control, audio
// - Hold-increment write adds one to count, ceiling 31; with a take in the same cycle only one is added in all
// - Hold-decrement write subtracts one, floor zero
// - Delivery only while hold count is zero
// - Taken interrupt adds one to count
// - Hold count readable and writable
// - Vectors 0x20 audio, 0x21 control, 0x22 data
// - Instruction RAM blocked while fetching from it
module dpr_peripheral
  import dpr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample path and clocking
  output dpr_sample_s dacSample,
  output logic dacStrobe,
  output logic doublerOn,
  // General purpose pins
  input wire logic [GPIO_W-1:0] gpioIn,
  output logic [GPIO_W-1:0] gpioOut,
  output logic [GPIO_W-1:0] gpioOe,
  // Interrupt sources and core side
  input wire logic ctrlPortReq,
  input wire logic dataPortReq,
  input wire logic irqAck,
  output logic irq,
  output logic [7:0] irqVector,
  // Instruction RAM arbitration
  input wire logic fetchFromRam,
  input wire logic iramReq,
  output logic iramGrant
);

  function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    regHit = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
  endfunction : regHit

  function automatic logic [CNT_W-1:0] cntStep(input logic [CNT_W-1:0] c, input logic up,
                                               input logic down);
    logic [CNT_W-1:0] r;
    r = c;
    if (up && !down && c != {CNT_W{1'b1}})
      r = c + 5'h01;
    else if (down && !up && c != RST_CNT)
      r = c - 5'h01;
    cntStep = r;
  endfunction : cntStep

  logic [15:0] stepLow_r;
  logic [4:0] stepHigh_r;
  dpr_sample_s sample_r;
  logic [GPIO_W-1:0] dir_r;
  logic [GPIO_W-1:0] outVal_r;
  logic [SRC_W-1:0] enable_r;
  logic [CNT_W-1:0] holdCnt_r;
  logic [SRC_W-1:0] status_r;
  logic [1:0] prescale_r;
  logic [ACC_W-1:0] acc_r;
  logic [GPIO_W-1:0] pinS1_r;
  logic [GPIO_W-1:0] pinS2_r;
  logic [GPIO_W-1:0] pinS3_r;
  logic [GPIO_W-1:0] pinLevel_r;
  dpr_phase_e phase_r;

  logic access;
  logic wrEn;
  logic rdHit;
  logic [31:0] rdData;
  logic [ACC_W:0] accSum;
  logic overflow;
  logic stepTick;
  logic [SRC_W-1:0] pending;
  logic take;
  logic [SRC_W-1:0] takeMask;
  logic [SRC_W-1:0] events;

  // One-wait answer: one access-phase cycle, then pready
  assign access = psel && penable && (phase_r == PH_WAIT);
  assign wrEn = access && pwrite && ce;

  always_comb
  begin
    rdHit = 1'b1;
    rdData = 32'h0000_0000;
    if (regHit(paddr, IDX_RATE_STEP_LOW))
      rdData = {16'h0000, stepLow_r};
    else if (regHit(paddr, IDX_RATE_STEP_HIGH_DOUBLER))
      rdData = {27'h0, stepHigh_r};
    else if (regHit(paddr, IDX_LEFT_SAMPLE_VALUE))
      rdData = {16'h0000, sample_r.left};
    else if (regHit(paddr, IDX_RIGHT_SAMPLE_VALUE))
      rdData = {16'h0000, sample_r.right};
    else if (regHit(paddr, IDX_PIN_DIRECTION))
      rdData = {28'h0, dir_r};
    else if (regHit(paddr, IDX_PIN_INPUT_LEVELS))
      rdData = {28'h0, pinLevel_r};
    else if (regHit(paddr, IDX_PIN_OUTPUT_LEVELS))
      rdData = {28'h0, outVal_r};
    else if (regHit(paddr, IDX_IRQ_SOURCE_ENABLE))
      rdData = {29'h0, enable_r};
    else if (regHit(paddr, IDX_IRQ_HOLD_INCREMENT) || regHit(paddr, IDX_IRQ_HOLD_DECREMENT))
      rdData = 32'h0000_0000;
    else if (regHit(paddr, IDX_IRQ_HOLD_COUNT))
      rdData = {27'h0, holdCnt_r};
    else if (regHit(paddr, IDX_IRQ_STATUS))
      rdData = {29'h0, status_r};
    else
      rdHit = 1'b0;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      phase_r <= PH_WAIT;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      case (phase_r)
        PH_WAIT:
        begin
          pready <= access;
          pslverr <= access && !rdHit;
          if (access)
          begin
            phase_r <= PH_DONE;
            prdata <= pwrite ? 32'h0000_0000 : rdData;
          end
        end
        PH_DONE:
        begin
          phase_r <= PH_WAIT;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default:
          phase_r <= PH_WAIT;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stepLow_r <= RST_WORD;
      stepHigh_r <= RST_HIGH;
      sample_r <= '0;
      dir_r <= RST_GPIO;
      outVal_r <= RST_GPIO;
      enable_r <= RST_SRC;
    end
    else if (wrEn)
    begin
      if (regHit(paddr, IDX_RATE_STEP_LOW))
        stepLow_r <= pwdata[15:0];
      if (regHit(paddr, IDX_RATE_STEP_HIGH_DOUBLER))
        stepHigh_r <= pwdata[4:0];
      if (regHit(paddr, IDX_LEFT_SAMPLE_VALUE))
        sample_r.left <= pwdata[15:0];
      if (regHit(paddr, IDX_RIGHT_SAMPLE_VALUE))
        sample_r.right <= pwdata[15:0];
      if (regHit(paddr, IDX_PIN_DIRECTION))
        dir_r <= pwdata[GPIO_W-1:0];
      // Written value kept regardless of direction
      if (regHit(paddr, IDX_PIN_OUTPUT_LEVELS))
        outVal_r <= pwdata[GPIO_W-1:0];
      // Takes effect next cycle, well inside the allowed lag
      if (regHit(paddr, IDX_IRQ_SOURCE_ENABLE))
        enable_r <= pwdata[SRC_W-1:0];
    end
  end

  // Rate generator
  assign stepTick = (prescale_r == STEP_PERIOD_M1);
  assign accSum = {1'b0, acc_r} + {1'b0, 6'h00, stepHigh_r[STEP_HIGH_W-1:0], stepLow_r};
  assign overflow = stepTick && accSum[ACC_W];

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      prescale_r <= 2'h0;
      acc_r <= '0;
    end
    else if (ce)
    begin
      prescale_r <= prescale_r + 2'h1;
      if (stepTick)
        acc_r <= accSum[ACC_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dacSample <= '0;
      dacStrobe <= 1'b0;
      doublerOn <= 1'b0;
    end
    else if (ce)
    begin
      dacStrobe <= overflow;
      if (overflow)
        dacSample <= sample_r;
      doublerOn <= stepHigh_r[DOUBLER_BIT];
    end
  end

  // Pins: three-stage sampling, a level counts once stages two and three agree
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pinS1_r <= RST_GPIO;
      pinS2_r <= RST_GPIO;
      pinS3_r <= RST_GPIO;
      pinLevel_r <= RST_GPIO;
      gpioOut <= RST_GPIO;
      gpioOe <= RST_GPIO;
    end
    else if (ce)
    begin
      pinS1_r <= gpioIn;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
      for (int i = 0; i < GPIO_W; i++)
        if (pinS2_r[i] == pinS3_r[i])
          pinLevel_r[i] <= pinS3_r[i];
      gpioOe <= dir_r;
      gpioOut <= outVal_r;
    end
  end

  // Interrupts: the pin port feeds no source here
  assign events = {dataPortReq, ctrlPortReq, overflow};
  assign pending = status_r & enable_r;
  assign take = irqAck && irq;

  always_comb
  begin
    takeMask = 3'h0;
    if (pending[SRC_AUDIO])
      takeMask[SRC_AUDIO] = 1'b1;
    else if (pending[SRC_CTRL])
      takeMask[SRC_CTRL] = 1'b1;
    else if (pending[SRC_DATA])
      takeMask[SRC_DATA] = 1'b1;
  end

  // Set wins over a software or acknowledge clear in the same cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      status_r <= RST_SRC;
    else if (ce)
      status_r <= (status_r & ~((wrEn && regHit(paddr, IDX_IRQ_STATUS)) ? pwdata[SRC_W-1:0] : 3'h0)
                   & ~(take ? takeMask : 3'h0)) | events;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      holdCnt_r <= RST_CNT;
    else if (ce)
    begin
      if (wrEn && regHit(paddr, IDX_IRQ_HOLD_COUNT))
        holdCnt_r <= pwdata[CNT_W-1:0];
      else
        holdCnt_r <= cntStep(holdCnt_r,
          (wrEn && regHit(paddr, IDX_IRQ_HOLD_INCREMENT)) || take,
          wrEn && regHit(paddr, IDX_IRQ_HOLD_DECREMENT));
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irq <= 1'b0;
      irqVector <= VEC_AUDIO;
    end
    else if (ce)
    begin
      // Dropped the cycle after a take so one request is never taken twice
      irq <= (|pending) && (holdCnt_r == RST_CNT) && !take;
      if (pending[SRC_AUDIO])
        irqVector <= VEC_AUDIO;
      else if (pending[SRC_CTRL])
        irqVector <= VEC_CTRL;
      else if (pending[SRC_DATA])
        irqVector <= VEC_DATA;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      iramGrant <= 1'b0;
    else if (ce)
      iramGrant <= iramReq && !fetchFromRam;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence hold_wr_s(logic [15:0] idx);
    wrEn && regHit(paddr, idx) && !irqAck;
  endsequence

  acc_step_a: assert property (ce && stepTick ##1 ce |->
    acc_r == $past(accSum[ACC_W-1:0])) else $error("accumulator step wrong");
  sample_take_a: assert property (ce && overflow |=> dacStrobe && dacSample == $past(sample_r)
    && status_r[SRC_AUDIO]) else $error("overflow did not take samples");
  tick_spacing_a: assert property (ce && stepTick ##1 ce[*3] |-> !stepTick)
    else $error("step tick not every fourth cycle");
  doubler_follow_a: assert property (ce |=> doublerOn == $past(stepHigh_r[DOUBLER_BIT]))
    else $error("doubler mismatch");
  pin_drive_a: assert property (ce |=> gpioOe == $past(dir_r) && gpioOut == $past(outVal_r))
    else $error("pin drive mismatch");
  hold_inc_a: assert property (hold_wr_s(IDX_IRQ_HOLD_INCREMENT) and ce
    and holdCnt_r != 5'h1F |=> holdCnt_r == $past(holdCnt_r) + 5'h01)
    else $error("hold increment failed");
  hold_dec_a: assert property (hold_wr_s(IDX_IRQ_HOLD_DECREMENT) and ce |=>
    holdCnt_r == (($past(holdCnt_r) == 5'h00) ? 5'h00 : $past(holdCnt_r) - 5'h01))
    else $error("hold decrement failed");
  irq_block_a: assert property (irq |-> $past(holdCnt_r) == 5'h00)
    else $error("irq while held");
  take_count_a: assert property (ce && take && !wrEn && holdCnt_r == 5'h00 |=>
    holdCnt_r == 5'h01 && !irq) else $error("take did not count");
  vector_a: assert property (irq && status_r[SRC_AUDIO] && enable_r[SRC_AUDIO] ##1 ce
    |-> irqVector == 8'h20) else $error("audio vector wrong");
  iram_block_a: assert property (ce && fetchFromRam |=> !iramGrant)
    else $error("iram granted during fetch");

endmodule : dpr_peripheral

// ### test/dpr_core_model.sv
`timescale 1ns/1ps
module dpr_core_model
  import dpr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Interrupt side
  input wire logic irq,
  input wire logic [7:0] irqVector,
  input wire logic [3:0] ackDelay,
  output logic irqAck,
  output logic [7:0] lastVec,
  output logic [7:0] takenCount
);
  logic [3:0] waitCnt;

  // Holding off ackDelay cycles mimics a core busy with a longer instruction
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irqAck <= 1'b0;
      lastVec <= 8'h00;
      takenCount <= 8'h00;
      waitCnt <= 4'h0;
    end
    else if (irqAck)
    begin
      irqAck <= 1'b0;
      waitCnt <= 4'h0;
    end
    else if (irq && waitCnt >= ackDelay)
    begin
      irqAck <= 1'b1;
      lastVec <= irqVector;
      takenCount <= takenCount + 8'h01;
    end
    else if (irq)
      waitCnt <= waitCnt + 4'h1;
  end
endmodule : dpr_core_model

// ### test/dpr_peripheral_tb.sv
`timescale 1ns/1ps
module dpr_peripheral_tb
  import dpr_pkg::*;
;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, lastErr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  dpr_sample_s dacSample;
  logic dacStrobe, doublerOn, ctrlPortReq, dataPortReq, irqAck, irq;
  logic [GPIO_W-1:0] gpioIn, gpioOut, gpioOe;
  logic [7:0] irqVector, lastVec, takenCount, t;
  logic fetchFromRam, iramReq, iramGrant, ce;
  logic [3:0] ackDelay;
  int failCount, numChecks, cyc, n;

  dpr_peripheral dpr_peripheral_inst (.clock(clock), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dacSample(dacSample), .dacStrobe(dacStrobe),
    .doublerOn(doublerOn), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .ctrlPortReq(ctrlPortReq), .dataPortReq(dataPortReq), .irqAck(irqAck), .irq(irq),
    .irqVector(irqVector), .fetchFromRam(fetchFromRam), .iramReq(iramReq),
    .iramGrant(iramGrant));

  dpr_core_model dpr_core_model_inst (.clock(clock), .rst(rst), .irq(irq),
    .irqVector(irqVector), .ackDelay(ackDelay), .irqAck(irqAck), .lastVec(lastVec),
    .takenCount(takenCount));

  always #5 clock = ~clock;

  task report_and_stop;
    if (failCount == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // Run takes about 1800 cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failCount++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      failCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Entered just after a rising edge; returns one idle cycle later
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
    output logic [31:0] rd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // Sampled at the rising edge, before that edge's updates land
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      failCount++;
      $display("[FAIL] %0t no pready", $time);
    end
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] v;
    apb(1'b1, idx, d, v);
  endtask : wr

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    apb(1'b0, idx, 32'h0, v);
    chk(v, exp);
  endtask : rd_chk

  task automatic wait_strobe();
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (dacStrobe !== 1'b1 && n < 2000);
    @(posedge clock);
  endtask : wait_strobe

  task automatic wait_take();
    t = takenCount;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (takenCount === t && n < 1000);
    @(posedge clock);
  endtask : wait_take

  task automatic pulse(input logic dataSide);
    ctrlPortReq <= !dataSide;
    dataPortReq <= dataSide;
    @(posedge clock);
    ctrlPortReq <= 1'b0;
    dataPortReq <= 1'b0;
    @(posedge clock);
  endtask : pulse

  initial
  begin
    clock = 0;
    rst = 1;
    {psel, penable, pwrite, ctrlPortReq, dataPortReq, fetchFromRam, iramReq} = '0;
    paddr = '0;
    pwdata = '0;
    gpioIn = 4'h0;
    ackDelay = 4'h0;
    ce = 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 11; i++)
      rd_chk(IDX_RATE_STEP_LOW + 16'(i), 32'h0);
    rd_chk(16'hC000, 32'h0);
    chk(32'(lastErr), 32'h1);
    wr(IDX_PIN_DIRECTION, 32'h5);
    wr(IDX_PIN_OUTPUT_LEVELS, 32'hA);
    chk(32'(gpioOe), 32'h5);
    chk(32'(gpioOut), 32'hA);
    gpioIn <= 4'h9;
    repeat (6) @(posedge clock);
    rd_chk(IDX_PIN_INPUT_LEVELS, 32'h9);
    wr(IDX_PIN_DIRECTION, 32'h0);
    chk(32'(gpioOe), 32'h0);
    rd_chk(IDX_PIN_OUTPUT_LEVELS, 32'hA);
    wr(IDX_PIN_DIRECTION, 32'hF);
    chk(32'(gpioOut), 32'hA);
    chk(32'(irq), 32'h0);
    rd_chk(IDX_IRQ_STATUS, 32'h0);
    wr(IDX_RATE_STEP_HIGH_DOUBLER, 32'h10);
    chk(32'(doublerOn), 32'h1);
    wr(IDX_LEFT_SAMPLE_VALUE, 32'h1234);
    wr(IDX_RIGHT_SAMPLE_VALUE, 32'h5678);
    // Step 0x80000 wraps the 26-bit sum every 128 ticks of 4 cycles
    wr(IDX_RATE_STEP_HIGH_DOUBLER, 32'h8);
    chk(32'(doublerOn), 32'h0);
    wait_strobe();
    wait_strobe();
    chk(n, 32'd512);
    chk(dacSample, 32'h12345678);
    wr(IDX_IRQ_STATUS, 32'h7);
    wr(IDX_IRQ_SOURCE_ENABLE, 32'h1);
    wait_take();
    wr(IDX_RATE_STEP_HIGH_DOUBLER, 32'h0);
    chk(32'(lastVec), 32'h20);
    rd_chk(IDX_IRQ_HOLD_COUNT, 32'h1);
    wr(IDX_IRQ_HOLD_DECREMENT, 32'h0);
    rd_chk(IDX_IRQ_HOLD_COUNT, 32'h0);
    wr(IDX_IRQ_STATUS, 32'h7);
    ackDelay <= 4'h5;
    wr(IDX_IRQ_SOURCE_ENABLE, 32'h3);
    pulse(1'b0);
    wait_take();
    chk(32'(lastVec), 32'h21);
    rd_chk(IDX_IRQ_HOLD_COUNT, 32'h1);
    wr(IDX_IRQ_HOLD_DECREMENT, 32'h0);
    pulse(1'b1);
    repeat (20) @(posedge clock);
    chk(32'(takenCount), 32'h2);
    wr(IDX_IRQ_HOLD_INCREMENT, 32'hBEEF);
    rd_chk(IDX_IRQ_HOLD_COUNT, 32'h1);
    wr(IDX_IRQ_SOURCE_ENABLE, 32'h4);
    repeat (20) @(posedge clock);
    chk(32'(irq), 32'h0);
    wr(IDX_IRQ_HOLD_DECREMENT, 32'h0);
    wait_take();
    chk(32'(lastVec), 32'h22);
    wr(IDX_IRQ_HOLD_DECREMENT, 32'h0);
    wr(IDX_IRQ_HOLD_DECREMENT, 32'h0);
    rd_chk(IDX_IRQ_HOLD_COUNT, 32'h0);
    wr(IDX_IRQ_HOLD_COUNT, 32'h5);
    rd_chk(IDX_IRQ_HOLD_COUNT, 32'h5);
    fetchFromRam <= 1'b1;
    iramReq <= 1'b1;
    repeat (3) @(posedge clock);
    chk(32'(iramGrant), 32'h0);
    fetchFromRam <= 1'b0;
    repeat (3) @(posedge clock);
    chk(32'(iramGrant), 32'h1);
    // Clock enable low must freeze the grant flop
    ce <= 1'b0;
    iramReq <= 1'b0;
    repeat (3) @(posedge clock);
    chk(32'(iramGrant), 32'h1);
    ce <= 1'b1;
    repeat (3) @(posedge clock);
    chk(32'(iramGrant), 32'h0);
    report_and_stop();
  end
endmodule : dpr_peripheral_tb
